// ==== rtl/pressure_fmt_pkg.sv ====
// constants, field layouts and carrier types of the pressure response formatter
// assumes one 100 MHz clock, a command parser ahead and a uart byte sink behind
// How it works
// - error status sent as four hex characters
// - error bits: uncomp, faults one-seven, limited eight
// - error bits nine to fifteen stay zero
// - out of range: clamp output, set bit eight
// - bits one to seven only from compensation faults
// - addressed command, serial mismatch: send nothing
// - serial number is twelve character traceability string
// - range: low, to, high, units, mode letter
// - temperature: low, space, high, space, C
// - echo, equals, hex out, space, hex errors, return
// - output word is 16-bit two's complement
// - standard or high resolution selects digital span
// - over/under pressure: one count beyond span
// - any non-limit error forces output to 8000
// - every response ends in carriage return
package pressure_fmt_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_SPAN_A = 12'h004;
   localparam logic [11:0] OFS_SPAN_B = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic [11:0] OFS_LAST_OUT = 12'h010;
   localparam logic [3:0] TEXT_PAGE = 4'h1; // text window 0x100..0x1fc, one char a word
   // control fields and reset values
   localparam int CTRL_HIRES_BIT = 0;
   localparam int CTRL_LETTER_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_4100; // letter 'A', standard resolution
   localparam logic [31:0] SPAN_A_RESET = 32'h0FFF_0000; // high limit in [31:16]
   localparam logic [31:0] SPAN_B_RESET = 32'h3FFF_0000;
   localparam int STATUS_BUSY_BIT = 16;
   // error word layout
   localparam int ERR_LIMITED_BIT = 8;
   localparam int ERR_FAULT_W = 8;
   localparam logic [15:0] FORCED_OUT = 16'h8000;
   // text memory fields: base and maximum length, a zero byte ends a field early
   localparam logic [5:0] FLD_PLO_BASE = 6'h00;
   localparam logic [5:0] FLD_PHI_BASE = 6'h08;
   localparam logic [5:0] FLD_UNIT_BASE = 6'h10;
   localparam logic [5:0] FLD_TLO_BASE = 6'h18;
   localparam logic [5:0] FLD_THI_BASE = 6'h1C;
   localparam logic [5:0] FLD_SN_BASE = 6'h20;
   localparam logic [3:0] FLD_LIMIT_LEN = 4'h8;
   localparam logic [3:0] FLD_TEMP_LEN = 4'h4;
   localparam logic [3:0] FLD_SN_LEN = 4'hC;
   // ascii characters
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_EQ = 8'h3D;
   localparam logic [7:0] CH_U = 8'h55;
   localparam logic [7:0] CH_T = 8'h74;
   localparam logic [7:0] CH_O = 8'h6F;
   localparam logic [7:0] CH_C = 8'h43;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // command kinds from the parser
   typedef enum logic [1:0] {K_PRESS, K_RANGE, K_TEMP, K_SERIAL} cmd_kind_e;
   typedef struct packed {
      cmd_kind_e kind;
      logic addressed; // command carried a serial number
      logic sn_match; // that serial equals our own
      logic [7:0] echo0; // two-letter command echo
      logic [7:0] echo1;
   } cmd_s;
   // compensation result
   typedef struct packed {
      logic signed [15:0] value;
      logic [7:0] fault; // bit 0 uncompensated, bits 1..7 arithmetic faults
      logic over;
      logic under;
   } comp_s;
   typedef enum logic [2:0] {OP_LIT, OP_FLD, OP_HEX_OUT, OP_HEX_ERR, OP_DONE} op_kind_e;
   typedef struct packed {
      op_kind_e kind;
      logic [7:0] lit;
      logic [5:0] base;
      logic [3:0] len;
   } op_s;
endpackage

// ==== rtl/text_mem.sv ====
// small character store: one write port, one registered read port
// assumes writer and reader share aclk
`timescale 1ns/1ps
module text_mem #(
   parameter int DEPTH = 64,
   parameter int WIDTH = 8,
   parameter int AW = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH]; // contents undefined until software loads them

   // write port, no reset on the array
   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read data always leaves through a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // text_mem

// ==== rtl/hex_ascii.sv ====
// one nibble to one uppercase ascii hex character
// purely combinational, caller registers the result
`timescale 1ns/1ps
module hex_ascii (
   input wire logic [3:0] nibble,
   output logic [7:0] ascii
);
   // letters start at 'A' = 0x41, so ten maps to 0x37 + 10
   always_comb begin
      if (nibble < 4'hA) begin
         ascii = 8'h30 + {4'h0, nibble};
      end else begin
         ascii = 8'h37 + {4'h0, nibble};
      end
   end
endmodule // hex_ascii

// ==== rtl/pressure_response_formatter.sv ====
// response builder of the serial command interface plus its axi4-lite registers
// assumes parser hands one command at a time; uart sink takes bytes by valid/ready
`timescale 1ns/1ps
module pressure_response_formatter
   import pressure_fmt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // command from the parser
   input wire cmd_s cmd,
   input wire logic cmd_valid,
   output logic cmd_ready,
   // compensation result, same clock
   input wire comp_s comp,
   // byte stream to the uart
   output logic [7:0] tx_byte,
   output logic tx_valid,
   input wire logic tx_ready
);
   typedef enum {S_IDLE, S_OP, S_MEMWAIT, S_SEND} fmt_state_e;

   // byte-lane merge of a write into a register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // registers seen by software
   logic [31:0] ctrl, next_ctrl; // hi-res bit and range mode letter
   logic [31:0] span_a, next_span_a; // standard resolution span
   logic [31:0] span_b, next_span_b; // high resolution span
   // axi write side
   logic aw_held, next_aw_held;
   logic [11:0] aw_addr_q, next_aw_addr_q;
   logic w_held, next_w_held;
   logic [31:0] w_data_q, next_w_data_q;
   logic [3:0] w_strb_q, next_w_strb_q;
   logic next_bvalid;
   logic [1:0] next_bresp;
   // axi read side
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   // text memory write port, driven straight from the write decode
   logic text_we;
   logic [5:0] text_waddr;
   logic [7:0] text_wdata;
   // formatter state
   fmt_state_e st, next_st;
   cmd_s cur, next_cur; // command being answered
   logic [4:0] step, next_step; // position in the response program
   logic [3:0] idx, next_idx; // char within a field or nibble within a word
   logic [15:0] out_q, next_out_q; // captured pressure output
   logic [15:0] err_q, next_err_q; // captured error word
   logic [7:0] next_tx_byte;
   logic next_tx_valid;
   logic [5:0] rd_addr, next_rd_addr;
   logic [7:0] rd_char; // text memory read data, one cycle after next_rd_addr, so in the same cycle as rd_addr
   logic [7:0] hex_char; // ascii of the selected nibble
   logic [3:0] nib;
   op_s op; // current program step
   // pressure path
   logic signed [15:0] span_lo, span_hi;
   logic p_over, p_under;
   logic [15:0] calc_out, calc_err;

   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign arready = !rvalid;
   assign cmd_ready = (st == S_IDLE);

   // register write path and answer; address and data may come in either order
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr_q = aw_addr_q;
      next_w_held = w_held;
      next_w_data_q = w_data_q;
      next_w_strb_q = w_strb_q;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_ctrl = ctrl;
      next_span_a = span_a;
      next_span_b = span_b;
      text_we = 1'b0;
      text_waddr = aw_addr_q[7:2];
      text_wdata = w_data_q[7:0];
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr_q = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_data_q = wdata;
         next_w_strb_q = wstrb;
      end
      if (aw_held && w_held) begin
         // both halves in hand: commit and answer next cycle
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         if (aw_addr_q == OFS_CTRL) begin
            next_ctrl = merge(ctrl, w_data_q, w_strb_q);
         end else if (aw_addr_q == OFS_SPAN_A) begin
            next_span_a = merge(span_a, w_data_q, w_strb_q);
         end else if (aw_addr_q == OFS_SPAN_B) begin
            next_span_b = merge(span_b, w_data_q, w_strb_q);
         end else if (aw_addr_q[11:8] == TEXT_PAGE) begin
            text_we = w_strb_q[0]; // only the low lane holds a character
         end else if (aw_addr_q == OFS_STATUS || aw_addr_q == OFS_LAST_OUT) begin
            next_bresp = RESP_OKAY; // read-only, write ignored
         end else begin
            next_bresp = RESP_SLVERR;
         end
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
   end

   // register read path; the text window reads back zero to keep one read port
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (araddr == OFS_CTRL) begin
            next_rdata = ctrl;
         end else if (araddr == OFS_SPAN_A) begin
            next_rdata = span_a;
         end else if (araddr == OFS_SPAN_B) begin
            next_rdata = span_b;
         end else if (araddr == OFS_STATUS) begin
            next_rdata = {15'h0000, (st != S_IDLE), err_q};
         end else if (araddr == OFS_LAST_OUT) begin
            next_rdata = {16'h0000, out_q};
         end else if (araddr[11:8] != TEXT_PAGE) begin
            next_rresp = RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
   end

   // bus registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr_q <= 12'h000;
         w_held <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
         ctrl <= CTRL_RESET;
         span_a <= SPAN_A_RESET;
         span_b <= SPAN_B_RESET;
      end else begin
         aw_held <= next_aw_held;
         aw_addr_q <= next_aw_addr_q;
         w_held <= next_w_held;
         w_data_q <= next_w_data_q;
         w_strb_q <= next_w_strb_q;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         ctrl <= next_ctrl;
         span_a <= next_span_a;
         span_b <= next_span_b;
      end
   end

   // pressure word and error word, from the live compensation result
   always_comb begin
      // span follows the resolution mode
      if (ctrl[CTRL_HIRES_BIT]) begin
         span_lo = signed'(span_b[15:0]);
         span_hi = signed'(span_b[31:16]);
      end else begin
         span_lo = signed'(span_a[15:0]);
         span_hi = signed'(span_a[31:16]);
      end
      // a value past the span counts as out of range even without the flag
      p_over = comp.over || (comp.value > span_hi);
      p_under = !p_over && (comp.under || (comp.value < span_lo));
      // bits 9..15 reserved and zero, 0..7 straight from the compensation
      calc_err = {7'h00, (p_over || p_under), comp.fault};
      if (comp.fault != 8'h00) begin
         calc_out = FORCED_OUT;
      end else if (p_over) begin
         calc_out = 16'(span_hi + 16'sd1);
      end else if (p_under) begin
         calc_out = 16'(span_lo - 16'sd1);
      end else begin
         calc_out = comp.value;
      end
   end

   // response program: prefix for addressed commands, then body per kind
   always_comb begin
      logic [4:0] s;
      s = step;
      op = '{kind: OP_DONE, lit: CH_CR, base: 6'h00, len: 4'h0};
      if (cur.addressed) begin
         // echo the address first: U, serial, space
         if (step == 5'd0) begin
            op.kind = OP_LIT;
            op.lit = CH_U;
         end else if (step == 5'd1) begin
            op = '{kind: OP_FLD, lit: CH_SP, base: FLD_SN_BASE, len: FLD_SN_LEN};
         end else if (step == 5'd2) begin
            op.kind = OP_LIT;
            op.lit = CH_SP;
         end
         s = step - 5'd3;
      end
      if (!cur.addressed || step > 5'd2) begin
         op.kind = OP_LIT;
         unique case (s)
            5'd0: op.lit = cur.echo0;
            5'd1: op.lit = cur.echo1;
            5'd2: op.lit = CH_EQ;
            default: op.kind = OP_LIT;
         endcase
         if (s > 5'd2) begin
            unique case (cur.kind)
               K_PRESS: begin
                  unique case (s)
                     5'd3: op.kind = OP_HEX_OUT;
                     5'd4: op.lit = CH_SP;
                     5'd5: op.kind = OP_HEX_ERR;
                     5'd6: op.lit = CH_CR;
                     default: op.kind = OP_DONE;
                  endcase
               end
               K_RANGE: begin
                  unique case (s)
                     5'd3: op = '{kind: OP_FLD, lit: CH_SP, base: FLD_PLO_BASE,
                                  len: FLD_LIMIT_LEN};
                     5'd4, 5'd7, 5'd9: op.lit = CH_SP;
                     5'd5: op.lit = CH_T;
                     5'd6: op.lit = CH_O;
                     5'd8: op = '{kind: OP_FLD, lit: CH_SP, base: FLD_PHI_BASE,
                                  len: FLD_LIMIT_LEN};
                     5'd10: op = '{kind: OP_FLD, lit: CH_SP, base: FLD_UNIT_BASE,
                                   len: FLD_LIMIT_LEN};
                     5'd11: op.lit = ctrl[CTRL_LETTER_LSB +: 8];
                     5'd12: op.lit = CH_CR;
                     default: op.kind = OP_DONE;
                  endcase
               end
               K_TEMP: begin
                  unique case (s)
                     5'd3: op = '{kind: OP_FLD, lit: CH_SP, base: FLD_TLO_BASE,
                                  len: FLD_TEMP_LEN};
                     5'd4, 5'd6: op.lit = CH_SP;
                     5'd5: op = '{kind: OP_FLD, lit: CH_SP, base: FLD_THI_BASE,
                                  len: FLD_TEMP_LEN};
                     5'd7: op.lit = CH_C;
                     5'd8: op.lit = CH_CR;
                     default: op.kind = OP_DONE;
                  endcase
               end
               K_SERIAL: begin
                  unique case (s)
                     5'd3: op = '{kind: OP_FLD, lit: CH_SP, base: FLD_SN_BASE,
                                  len: FLD_SN_LEN};
                     5'd4: op.lit = CH_CR;
                     default: op.kind = OP_DONE;
                  endcase
               end
            endcase
         end
      end
   end

   // most significant nibble goes first
   assign nib = (op.kind == OP_HEX_ERR) ? err_q[4'(4'd12 - {idx[1:0], 2'b00}) +: 4]
                                         : out_q[4'(4'd12 - {idx[1:0], 2'b00}) +: 4];

   // formatter sequencer: one byte per pass through S_SEND, fields walked through the text memory
   always_comb begin
      next_st = st;
      next_cur = cur;
      next_step = step;
      next_idx = idx;
      next_out_q = out_q;
      next_err_q = err_q;
      next_tx_byte = tx_byte;
      next_tx_valid = tx_valid;
      next_rd_addr = rd_addr;
      unique case (st)
         S_IDLE: begin
            if (cmd_valid) begin
               // serial mismatch: swallow the command, keep the line quiet
               if (!(cmd.addressed && !cmd.sn_match)) begin
                  next_st = S_OP;
                  next_cur = cmd;
                  next_step = 5'd0;
                  next_idx = 4'h0;
                  if (cmd.kind == K_PRESS) begin
                     next_out_q = calc_out;
                     next_err_q = calc_err;
                  end
               end
            end
         end
         S_OP: begin
            unique case (op.kind)
               OP_DONE: next_st = S_IDLE;
               OP_LIT: begin
                  next_tx_byte = op.lit;
                  next_tx_valid = 1'b1;
                  next_st = S_SEND;
               end
               OP_FLD: begin
                  if (idx == op.len) begin
                     next_step = step + 5'd1;
                     next_idx = 4'h0;
                  end else begin
                     next_rd_addr = op.base + {2'b00, idx};
                     next_st = S_MEMWAIT;
                  end
               end
               OP_HEX_OUT, OP_HEX_ERR: begin
                  next_tx_byte = hex_char;
                  next_tx_valid = 1'b1;
                  next_st = S_SEND;
               end
            endcase
         end
         S_MEMWAIT: begin
            // zero byte marks a short field
            if (rd_char == 8'h00) begin
               next_step = step + 5'd1;
               next_idx = 4'h0;
               next_st = S_OP;
            end else begin
               next_tx_byte = rd_char;
               next_tx_valid = 1'b1;
               next_st = S_SEND;
            end
         end
         S_SEND: begin
            if (tx_ready) begin
               next_tx_valid = 1'b0;
               next_st = S_OP;
               if (op.kind == OP_FLD) begin
                  next_idx = idx + 4'h1;
               end else if ((op.kind == OP_HEX_OUT || op.kind == OP_HEX_ERR) &&
                            idx != 4'h3) begin
                  next_idx = idx + 4'h1;
               end else begin
                  next_idx = 4'h0;
                  next_step = step + 5'd1;
               end
            end
         end
      endcase
   end

   // formatter registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= S_IDLE;
         cur <= '0;
         step <= 5'd0;
         idx <= 4'h0;
         out_q <= 16'h0000;
         err_q <= 16'h0000;
         tx_byte <= 8'h00;
         tx_valid <= 1'b0;
         rd_addr <= 6'h00;
      end else begin
         st <= next_st;
         cur <= next_cur;
         step <= next_step;
         idx <= next_idx;
         out_q <= next_out_q;
         err_q <= next_err_q;
         tx_byte <= next_tx_byte;
         tx_valid <= next_tx_valid;
         rd_addr <= next_rd_addr;
      end
   end

   // character store for limits, units and serial number
   text_mem #(.DEPTH(64), .WIDTH(8), .AW(6)) u_text (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(text_we),
      .wr_addr(text_waddr),
      .wr_data(text_wdata),
      .rd_addr(next_rd_addr),
      .rd_data(rd_char)
   );

   // nibble to ascii
   hex_ascii u_hex (
      .nibble(nib),
      .ascii(hex_char)
   );
endmodule // pressure_response_formatter

// ==== verif/pressure_response_formatter_chk.sv ====
// assertions on the formatter's stream, command and axi answer ports
// bound into every formatter instance, sees only its ports
`timescale 1ns/1ps
module pressure_response_formatter_chk
   import pressure_fmt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bready,
   input wire logic bvalid,
   input wire logic [1:0] bresp,
   input wire logic rready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic arvalid,
   input wire logic arready,
   input wire cmd_s cmd,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_ready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire take = cmd_valid && cmd_ready; // command accepted this edge
   wire mute = cmd.addressed && !cmd.sn_match; // meant for another sensor
   property p_mute; take && mute |=> !tx_valid [*8]; endproperty
   a_mute: assert property (p_mute) else $error("bytes after serial mismatch");
   property p_first; take && !mute |-> ##[1:3] tx_valid; endproperty
   a_first: assert property (p_first) else $error("no first byte");
   property p_end; tx_valid && tx_ready && tx_byte == CH_CR |-> ##[1:4] cmd_ready; endproperty
   a_end: assert property (p_end) else $error("not idle after return");
   property p_busy; tx_valid |-> !cmd_ready; endproperty
   a_busy: assert property (p_busy) else $error("command taken mid response");
   property p_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
   a_gap: assert property (p_gap) else $error("no gap after byte");
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
   a_hold: assert property (p_hold) else $error("byte dropped while stalled");
   property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_rans; arvalid && arready |=> rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   // main scenarios reached
   c_mute: cover property (take && mute);
   c_stall: cover property (tx_valid && !tx_ready);
   c_err: cover property (bvalid && bready && bresp == RESP_SLVERR);
endmodule // pressure_response_formatter_chk

bind pressure_response_formatter pressure_response_formatter_chk pressure_response_formatter_chk_i (
   .aclk, .aresetn, .bready, .bvalid, .bresp, .rready, .rvalid, .rdata, .arvalid,
   .arready, .cmd, .cmd_valid, .cmd_ready, .tx_byte, .tx_valid, .tx_ready);

// ==== verif/uart_host_model.sv ====
// byte sink standing for the host behind the serial line
// assumes one clock; slow takes one byte in three cycles
`timescale 1ns/1ps
module uart_host_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [1:0] cnt; // stall pacing
   int lines = 0; // responses closed so far
   // pacing counter and end-of-line tally
   always @(posedge aclk) begin
      cnt <= (!aresetn || cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
      if (tx_valid && tx_ready && tx_byte == 8'h0D) lines <= lines + 1;
   end
   assign tx_ready = !slow || cnt == 2'h2;
endmodule // uart_host_model

// ==== verif/tb_pressure_response_formatter.sv ====
// self-checking bench: axi4-lite tasks and command sequences
// assumes the host model on the byte stream and the bound checker
`timescale 1ns/1ps
module tb_pressure_response_formatter
   import pressure_fmt_pkg::*;
();
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic cmd_valid = 0, slow = 0, awready, wready, bvalid, arready, rvalid, cmd_ready;
   logic tx_valid, tx_ready;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0] tx_byte, q[$]; // q holds the bytes seen on the stream
   cmd_s cmd = '0;
   comp_s comp = '0;
   int error_cnt = 0, total_checks = 0;
   always #5 aclk = ~aclk;
   pressure_response_formatter pressure_response_formatter_i (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cmd, .cmd_valid,
      .cmd_ready, .comp, .tx_byte, .tx_valid, .tx_ready);
   uart_host_model uart_host_model_i (.aclk, .aresetn, .slow, .tx_byte, .tx_valid, .tx_ready);
   // collect every byte handed over
   always @(posedge aclk) if (tx_valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx_byte);
   task automatic give_verdict();
      $display("errors %0d checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_str(input string e);
      logic bad;
      total_checks++;
      bad = (q.size() != e.len());
      foreach (q[i]) if (!bad && q[i] !== e[i]) bad = 1;
      if (bad) begin
         error_cnt++;
         $display("Error %0t stream mismatch, exp %s", $time, e);
      end
   endtask
   // one edge with a bound on the whole wait
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 500) begin
         error_cnt++;
         $display("Error %0t timeout", $time);
         give_verdict();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      do begin
         tick(n);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      while (!bvalid) tick(n);
      bready <= 1;
      tick(n);
      chk(bresp, er);
      bready <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      do tick(n); while (!arready);
      arvalid <= 0;
      while (!rvalid) tick(n);
      rready <= 1;
      tick(n);
      chk(rdata, ed);
      chk(rresp, er);
      rready <= 0;
   endtask
   // load one text field, zero padded
   task automatic txt(input int b, input int l, input string s);
      for (int i = 0; i < l; i++) wr(12'h100 + 12'(4 * (b + i)), (i < s.len()) ? 32'(s[i]) : 0, 0);
   endtask
   task automatic run(input cmd_kind_e k, input logic ad, input logic m, input logic [7:0] e1,
      input logic [15:0] v, input logic [7:0] fl, input logic ov, input logic un, input string e);
      int n = 0;
      q.delete();
      @(posedge aclk);
      cmd <= '{k, ad, m, 8'h52, e1};
      comp <= '{v, fl, ov, un};
      cmd_valid <= 1;
      do tick(n); while (!cmd_ready);
      cmd_valid <= 0;
      for (int i = 0; i < 300 && !(q.size() > 0 && q[$] == CH_CR); i++) @(posedge aclk);
      chk_str(e);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      rd(OFS_CTRL, CTRL_RESET, RESP_OKAY);
      rd(OFS_SPAN_A, SPAN_A_RESET, RESP_OKAY);
      rd(OFS_SPAN_B, SPAN_B_RESET, RESP_OKAY);
      rd(12'h020, 0, RESP_SLVERR);
      wr(12'h020, 32'h1234_5678, RESP_SLVERR);
      txt(0, 8, "0");
      txt(8, 8, "15");
      txt(16, 8, "PSI");
      txt(24, 4, "-40");
      txt(28, 4, "125");
      txt(32, 12, "3D23-03-A103");
      wr(OFS_CTRL, 32'h0000_4400, RESP_OKAY);
      run(K_PRESS, 0, 0, "C", 16'h0ABC, 8'h00, 0, 0, "RC=0ABC 0000\015");
      run(K_PRESS, 0, 0, "C", 16'h0234, 8'h01, 0, 0, "RC=8000 0001\015");
      run(K_PRESS, 0, 0, "C", 16'h0234, 8'hFE, 0, 0, "RC=8000 00FE\015");
      run(K_PRESS, 0, 0, "C", 16'h0100, 8'h00, 1, 0, "RC=1000 0100\015");
      run(K_PRESS, 0, 0, "C", 16'hFFFB, 8'h00, 0, 0, "RC=FFFF 0100\015");
      run(K_PRESS, 0, 0, "C", 16'h0100, 8'h02, 1, 0, "RC=8000 0102\015");
      run(K_RANGE, 0, 0, "R", 16'h0000, 8'h00, 0, 0, "RR=0 to 15 PSID\015");
      slow <= 1;
      run(K_TEMP, 0, 0, "T", 16'h0000, 8'h00, 0, 0, "RT=-40 125 C\015");
      run(K_SERIAL, 0, 0, "S", 16'h0000, 8'h00, 0, 0, "RS=3D23-03-A103\015");
      run(K_PRESS, 1, 1, "C", 16'h0001, 8'h00, 0, 0, "U3D23-03-A103 RC=0001 0000\015");
      run(K_PRESS, 1, 0, "C", 16'h0001, 8'h00, 0, 0, "");
      wr(OFS_CTRL, 32'h0000_4401, RESP_OKAY);
      run(K_PRESS, 0, 0, "C", 16'h0100, 8'h00, 1, 0, "RC=4000 0100\015");
      rd(OFS_STATUS, 32'h0000_0100, RESP_OKAY);
      rd(OFS_LAST_OUT, 32'h0000_4000, RESP_OKAY);
      chk(uart_host_model_i.lines, 11);
      give_verdict();
   end
endmodule // tb_pressure_response_formatter
